// >>> logic/col_pkg.sv
// Constants and types shared by the output line control block
`default_nettype none
package col_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned TICK_CYCLES = US_NS / CLK_PERIOD_NS;
	localparam int unsigned EXPO_LATENCY_US = 68;
	localparam int unsigned US_W = 26;
	localparam int unsigned DLY_W = 16;

	localparam logic [25:0] PULSE_MAX_US = 26'h393_8700;
	localparam logic [25:0] PULSE_MIN_PERIOD_US = 26'h000_0001;
	localparam logic [25:0] PERIOD_RST = 26'h000_03E8;
	localparam logic [25:0] WIDTH_RST = 26'h000_01F4;
	localparam logic [15:0] DELAY_RST = 16'h0000;

	localparam logic [7:0] OFS_LINE_CTRL = 8'h00;
	localparam logic [7:0] OFS_PULSE_PERIOD = 8'h04;
	localparam logic [7:0] OFS_PULSE_WIDTH = 8'h08;
	localparam logic [7:0] OFS_STROBE_DELAY = 8'h0C;
	localparam logic [7:0] OFS_EVT_CTRL = 8'h10;
	localparam logic [7:0] OFS_TS_CMD = 8'h14;
	localparam logic [7:0] OFS_TS_LO = 8'h18;
	localparam logic [7:0] OFS_TS_HI = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_LINE_STATUS = 8'h28;

	localparam int unsigned LC_INV_BIT = 0;
	localparam int unsigned LC_SRC_LSB = 1;
	localparam int unsigned LC_MAN_BIT = 4;
	localparam int unsigned EV_EN_BIT = 0;
	localparam int unsigned EV_TYPE_LSB = 4;
	localparam int unsigned TS_LATCH_BIT = 0;
	localparam int unsigned TS_RESET_BIT = 1;

	typedef enum logic [2:0] {
		SRC_OFF = 3'h0,
		SRC_EXPOSURE = 3'h1,
		SRC_READOUT = 3'h2,
		SRC_STROBE = 3'h3,
		SRC_PULSE = 3'h4,
		SRC_MANUAL = 3'h5
	} col_src_t;

	typedef enum logic [3:0] {
		EVT_EXPOSURE_END = 4'h0
	} col_evt_t;
endpackage
`default_nettype wire

// >>> logic/col_edge_delay.sv
// Level delay line that shifts each edge later by a count of microsecond ticks
`default_nettype none
module col_edge_delay
	import col_pkg::*;
#(
	parameter int unsigned W = DLY_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic din,
	input wire logic [W-1:0] delay_us,
	output logic dout
);
	// One pending rise and one pending fall: edges of the same kind closer
	// than the delay merge, which suits exposure-length pulses.
	logic din_ff, rise_pend_ff, fall_pend_ff, dout_ff;
	logic [W-1:0] rise_cnt_ff, fall_cnt_ff;
	logic rise, fall, rise_fire, fall_fire, zero_dly;

	assign rise = din & ~din_ff;
	assign fall = ~din & din_ff;
	assign zero_dly = (delay_us == '0);
	assign rise_fire = (rise & zero_dly) | (rise_pend_ff & tick & (rise_cnt_ff == W'(1)));
	assign fall_fire = (fall & zero_dly) | (fall_pend_ff & tick & (fall_cnt_ff == W'(1)));
	assign dout = dout_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_ff <= 1'b0;
		end else begin
			din_ff <= din;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_pend_ff <= 1'b0;
			rise_cnt_ff <= '0;
		end else if (rise) begin
			rise_pend_ff <= ~zero_dly;
			rise_cnt_ff <= delay_us;
		end else if (rise_pend_ff && tick) begin
			rise_pend_ff <= (rise_cnt_ff != W'(1));
			rise_cnt_ff <= rise_cnt_ff - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fall_pend_ff <= 1'b0;
			fall_cnt_ff <= '0;
		end else if (fall) begin
			fall_pend_ff <= ~zero_dly;
			fall_cnt_ff <= delay_us;
		end else if (fall_pend_ff && tick) begin
			fall_pend_ff <= (fall_cnt_ff != W'(1));
			fall_cnt_ff <= fall_cnt_ff - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_ff <= 1'b0;
		end else if (rise_fire) begin
			dout_ff <= 1'b1;
		end else if (fall_fire) begin
			dout_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> logic/col_pulse_gen.sv
// Free-running pulse generator counting in microsecond ticks
`default_nettype none
module col_pulse_gen
	import col_pkg::*;
#(
	parameter int unsigned W = US_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [W-1:0] period_us,
	input wire logic [W-1:0] width_us,
	output logic pulse
);
	logic [W-1:0] phase_ff;
	logic pulse_ff;

	assign pulse = pulse_ff;

	// Wrap on >= so that shrinking the period never strands the phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= '0;
		end else if (tick) begin
			phase_ff <= (phase_ff >= period_us - W'(1)) ? '0 : phase_ff + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= (phase_ff < width_us);
		end
	end
endmodule
`default_nettype wire

// >>> logic/col_line_ctrl.sv
// Programmable output line, exposure-end event and timestamp control with APB registers
`default_nettype none
// What this block does
// - Invert setting complements the selected source, except off and the unused codes
// - Source off keeps the line low
// - Exposure source follows each exposure window
// - Readout source follows frame readout window
// - Delayed source is exposure shifted by delay
// - Pulse source repeats software period and width
// - Manual source drives line from level value
// - Manual level reaches line only when selected
// - Pulse period accepted from 1 to 60000000
// - Pulse width accepted from 0 to 60000000
// - Strobe delay 0 to 65535, delayed source only
// - Exposure window rises at start, falls at end
// - Exposure window lags exposure by 68 us
// - Enabled exposure end raises event, else none
// - Exposure end is the only event type
// - Latch command copies running timestamp
// - Reset command zeroes timestamp, counting continues
module col_line_ctrl
	import col_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic exposure_raw,
	input wire logic readout_window_signal,
	output logic output_line,
	output logic exposure_window_signal,
	output logic exposure_finished_event,
	output logic irq
);
	localparam int TICK_GAP = TICK_CYCLES;
	localparam int TICK_MID = TICK_GAP - 2;
	localparam int LAT_MIN = 2675;
	localparam int LAT_MAX = 2730;

	logic [5:0] div_ff;
	logic tick_ff;
	logic output_invert_enable_ff, manual_level_value_ff;
	col_src_t output_source_select_ff;
	logic [US_W-1:0] pulse_period_us_ff, pulse_width_us_ff;
	logic [DLY_W-1:0] strobe_delay_us_ff;
	logic evt_enable_ff;
	col_evt_t event_type_choice_ff;
	logic [63:0] ts_ff, ts_hold_ff;
	logic irq_status_ff, irq_mask_ff, irq_ff, evt_ff, line_ff;
	logic raw_q_ff, expo_end;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic wr_en, rd_setup, ts_latch_cmd, ts_reset_cmd;
	logic expo_win, delayed_exposure_source, periodic_pulse_source;
	logic src_level, nxt_line;

	function automatic logic [US_W-1:0] clamp_us(input logic [31:0] v, input logic [US_W-1:0] lo);
		logic [31:0] r;
		r = v;
		if (r > {6'h00, PULSE_MAX_US}) begin
			r = {6'h00, PULSE_MAX_US};
		end
		if (r < {6'h00, lo}) begin
			r = {6'h00, lo};
		end
		return r[US_W-1:0];
	endfunction

	function automatic logic known_ofs(input logic [7:0] a);
		return a == OFS_LINE_CTRL || a == OFS_PULSE_PERIOD || a == OFS_PULSE_WIDTH
			|| a == OFS_STROBE_DELAY || a == OFS_EVT_CTRL || a == OFS_TS_CMD
			|| a == OFS_TS_LO || a == OFS_TS_HI || a == OFS_IRQ_STATUS
			|| a == OFS_IRQ_MASK || a == OFS_LINE_STATUS;
	endfunction

	assign wr_en = psel & penable & pready_ff & pwrite & known_ofs(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;
	assign ts_latch_cmd = wr_en & (paddr == OFS_TS_CMD) & pwdata[TS_LATCH_BIT];
	assign ts_reset_cmd = wr_en & (paddr == OFS_TS_CMD) & pwdata[TS_RESET_BIT];
	assign expo_end = ~exposure_raw & raw_q_ff;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign output_line = line_ff;
	assign exposure_window_signal = expo_win;
	assign exposure_finished_event = evt_ff;
	assign irq = irq_ff;

	// Microsecond timebase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else if (div_ff == 6'(TICK_CYCLES - 1)) begin
			div_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 6'h01;
			tick_ff <= 1'b0;
		end
	end

	// APB: no wait state, as read data is registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel & ~penable;
			pslverr_ff <= psel & ~penable & ~known_ofs(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (rd_setup) begin
			unique case (paddr)
				OFS_LINE_CTRL: prdata_ff <= {27'h000_0000, manual_level_value_ff,
					output_source_select_ff, output_invert_enable_ff};
				OFS_PULSE_PERIOD: prdata_ff <= {6'h00, pulse_period_us_ff};
				OFS_PULSE_WIDTH: prdata_ff <= {6'h00, pulse_width_us_ff};
				OFS_STROBE_DELAY: prdata_ff <= {16'h0000, strobe_delay_us_ff};
				OFS_EVT_CTRL: prdata_ff <= {24'h00_0000, event_type_choice_ff, 3'h0,
					evt_enable_ff};
				OFS_TS_LO: prdata_ff <= ts_hold_ff[31:0];
				OFS_TS_HI: prdata_ff <= ts_hold_ff[63:32];
				OFS_IRQ_STATUS: prdata_ff <= {31'h0000_0000, irq_status_ff};
				OFS_IRQ_MASK: prdata_ff <= {31'h0000_0000, irq_mask_ff};
				OFS_LINE_STATUS: prdata_ff <= {27'h000_0000, periodic_pulse_source,
					delayed_exposure_source, readout_window_signal, expo_win, line_ff};
				default: prdata_ff <= '0;
			endcase
		end
	end

	// Line configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_invert_enable_ff <= 1'b0;
			output_source_select_ff <= SRC_OFF;
			manual_level_value_ff <= 1'b0;
		end else if (wr_en && paddr == OFS_LINE_CTRL) begin
			output_invert_enable_ff <= pwdata[LC_INV_BIT];
			output_source_select_ff <= col_src_t'(pwdata[LC_SRC_LSB +: 3]);
			manual_level_value_ff <= pwdata[LC_MAN_BIT];
		end
	end

	// Out-of-range period and width are clamped; the strobe delay keeps its low 16 bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_period_us_ff <= PERIOD_RST;
			pulse_width_us_ff <= WIDTH_RST;
			strobe_delay_us_ff <= DELAY_RST;
		end else if (wr_en) begin
			if (paddr == OFS_PULSE_PERIOD) begin
				pulse_period_us_ff <= clamp_us(pwdata, PULSE_MIN_PERIOD_US);
			end
			if (paddr == OFS_PULSE_WIDTH) begin
				pulse_width_us_ff <= clamp_us(pwdata, '0);
			end
			if (paddr == OFS_STROBE_DELAY) begin
				strobe_delay_us_ff <= pwdata[DLY_W-1:0];
			end
		end
	end

	// Only the exposure-end type is accepted; other choices are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_enable_ff <= 1'b0;
			event_type_choice_ff <= EVT_EXPOSURE_END;
		end else if (wr_en && paddr == OFS_EVT_CTRL
				&& pwdata[EV_TYPE_LSB +: 4] == EVT_EXPOSURE_END) begin
			event_type_choice_ff <= EVT_EXPOSURE_END;
			evt_enable_ff <= pwdata[EV_EN_BIT];
		end
	end

	// Exposure window path, sensor exposure delayed by the fixed latency
	col_edge_delay #(.W(DLY_W)) u_expo_dly (
		.clk(pclk),
		.rst_n(presetn),
		.tick(tick_ff),
		.din(exposure_raw),
		.delay_us(DLY_W'(EXPO_LATENCY_US)),
		.dout(expo_win)
	);

	col_edge_delay #(.W(DLY_W)) u_strobe_dly (
		.clk(pclk),
		.rst_n(presetn),
		.tick(tick_ff),
		.din(expo_win),
		.delay_us(strobe_delay_us_ff),
		.dout(delayed_exposure_source)
	);

	col_pulse_gen #(.W(US_W)) u_pulse (
		.clk(pclk),
		.rst_n(presetn),
		.tick(tick_ff),
		.period_us(pulse_period_us_ff),
		.width_us(pulse_width_us_ff),
		.pulse(periodic_pulse_source)
	);

	always_comb begin
		unique case (output_source_select_ff)
			SRC_OFF: src_level = 1'b0;
			SRC_EXPOSURE: src_level = expo_win;
			SRC_READOUT: src_level = readout_window_signal;
			SRC_STROBE: src_level = delayed_exposure_source;
			SRC_PULSE: src_level = periodic_pulse_source;
			SRC_MANUAL: src_level = manual_level_value_ff;
			default: src_level = 1'b0;
		endcase
		// Off and the unused codes stay inactive even when inverted
		if (output_source_select_ff == SRC_OFF || output_source_select_ff > SRC_MANUAL) begin
			nxt_line = 1'b0;
		end else begin
			nxt_line = src_level ^ output_invert_enable_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_ff <= 1'b0;
		end else begin
			line_ff <= nxt_line;
		end
	end

	// Exposure end event and interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_q_ff <= 1'b0;
			evt_ff <= 1'b0;
		end else begin
			raw_q_ff <= exposure_raw;
			evt_ff <= expo_end & evt_enable_ff;
		end
	end

	// A new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff <= 1'b0;
			irq_mask_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			if (evt_ff) begin
				irq_status_ff <= 1'b1;
			end else if (wr_en && paddr == OFS_IRQ_STATUS && pwdata[0]) begin
				irq_status_ff <= 1'b0;
			end
			if (wr_en && paddr == OFS_IRQ_MASK) begin
				irq_mask_ff <= pwdata[0];
			end
			irq_ff <= irq_status_ff & irq_mask_ff;
		end
	end

	// Running timestamp in microseconds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_ff <= '0;
		end else if (ts_reset_cmd) begin
			ts_ff <= '0;
		end else if (tick_ff) begin
			ts_ff <= ts_ff + 64'h0000_0000_0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_hold_ff <= '0;
		end else if (ts_latch_cmd) begin
			ts_hold_ff <= ts_ff;
		end
	end

	// Latency watch: cycles from exposure start until the window rises
	logic [11:0] lat_cnt_ff;
	logic win_q_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q_ff <= 1'b0;
			lat_cnt_ff <= '0;
		end else begin
			win_q_ff <= expo_win;
			if (exposure_raw && !raw_q_ff) begin
				lat_cnt_ff <= 12'h001;
			end else if (expo_win && !win_q_ff) begin
				lat_cnt_ff <= 12'h000;
			end else if (lat_cnt_ff != 12'h000 && lat_cnt_ff != 12'hFFF) begin
				lat_cnt_ff <= lat_cnt_ff + 12'h001;
			end
		end
	end

	sequence s_win_rise;
		$rose(expo_win);
	endsequence

	chk_off_low: assert property (@(posedge pclk) disable iff (!presetn)
		output_source_select_ff == SRC_OFF |=> !line_ff)
		else $error("line active while source off");

	chk_invert_expo: assert property (@(posedge pclk) disable iff (!presetn)
		output_source_select_ff == SRC_EXPOSURE |=>
		line_ff == ($past(expo_win) ^ $past(output_invert_enable_ff)))
		else $error("exposure source or inversion wrong on line");

	chk_readout_pass: assert property (@(posedge pclk) disable iff (!presetn)
		output_source_select_ff == SRC_READOUT && !output_invert_enable_ff |=>
		line_ff == $past(readout_window_signal))
		else $error("readout window not on line");

	chk_manual_level: assert property (@(posedge pclk) disable iff (!presetn)
		output_source_select_ff == SRC_MANUAL && !output_invert_enable_ff |=>
		line_ff == $past(manual_level_value_ff))
		else $error("manual level not on line");

	chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		tick_ff |=> !tick_ff ##TICK_MID !tick_ff ##1 tick_ff)
		else $error("microsecond tick spacing wrong");

	chk_expo_latency: assert property (@(posedge pclk) disable iff (!presetn)
		s_win_rise |-> lat_cnt_ff >= 12'(LAT_MIN) && lat_cnt_ff <= 12'(LAT_MAX))
		else $error("exposure window latency out of bounds");

	chk_expo_deadline: assert property (@(posedge pclk) disable iff (!presetn)
		lat_cnt_ff <= 12'(LAT_MAX))
		else $error("exposure window did not rise in time");

	chk_event_gated: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(exposure_raw) |=> exposure_finished_event == $past(evt_enable_ff))
		else $error("exposure end event gating wrong");

	chk_ts_reset: assert property (@(posedge pclk) disable iff (!presetn)
		ts_reset_cmd |=> ts_ff == 64'h0000_0000_0000_0000 ##TICK_GAP ts_ff != 64'h0)
		else $error("timestamp did not restart from zero");

	chk_ts_latch: assert property (@(posedge pclk) disable iff (!presetn)
		ts_latch_cmd |=> ts_hold_ff == $past(ts_ff))
		else $error("timestamp latch value wrong");
endmodule
`default_nettype wire

// >>> dv/col_frame_model.sv
// Sensor-side model: one exposure then a readout window per frame request
`default_nettype none
module col_frame_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frame_go,
	input wire logic [15:0] expo_cycles,
	output logic exposure_raw,
	output logic readout_window_signal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_ff;
	logic [15:0] cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= 2'h0;
			cnt_ff <= 16'h0000;
		end else begin
			case (phase_ff)
				2'h0: if (frame_go) begin
					phase_ff <= 2'h1;
					cnt_ff <= expo_cycles;
				end
				2'h1: if (cnt_ff == 16'h0001) begin
					// Readout always follows the exposure, as on a real sensor
					phase_ff <= 2'h2;
					cnt_ff <= 16'h0078;
				end else begin
					cnt_ff <= cnt_ff - 16'h0001;
				end
				2'h2: if (cnt_ff == 16'h0001) begin
					phase_ff <= 2'h0;
				end else begin
					cnt_ff <= cnt_ff - 16'h0001;
				end
				default: phase_ff <= 2'h0;
			endcase
		end
	end
	assign exposure_raw = (phase_ff == 2'h1);
	assign readout_window_signal = (phase_ff == 2'h2);
endmodule
`default_nettype wire

// >>> dv/col_line_ctrl_tb_top.sv
// Self-checking bench for the output line control block
`default_nettype none
module col_line_ctrl_tb_top;
	import col_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic expo, ro, line, win, evt, irq, go, err;
	logic [15:0] expo_len;
	int fail_count, samples_checked, n;
	col_line_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exposure_raw(expo),
		.readout_window_signal(ro), .output_line(line), .exposure_window_signal(win),
		.exposure_finished_event(evt), .irq(irq));
	col_frame_model frame_model (.pclk(pclk), .presetn(presetn), .frame_go(go),
		.expo_cycles(expo_len), .exposure_raw(expo), .readout_window_signal(ro));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rng(input string nm, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chk("pready", 1, 0);
			give_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rdat);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return line;
			1: return win;
			2: return evt;
			default: return irq;
		endcase
	endfunction
	// Bounded wait; n is the number of edges passed
	task automatic wait_sig(input int s, input logic v);
		n = 0;
		while (sig(s) !== v && n < 6000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 6000) begin
			chk("wait", 1, 0);
			give_verdict();
		end
	endtask
	task automatic frame(input logic [15:0] len);
		@(posedge pclk);
		expo_len <= len;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask
	task automatic t_regs();
		rd(OFS_LINE_CTRL, 32'h0000_0000, "ctrl");
		rd(OFS_PULSE_PERIOD, 32'(PERIOD_RST), "period");
		rd(OFS_PULSE_WIDTH, 32'(WIDTH_RST), "width");
		rd(OFS_STROBE_DELAY, 32'(DELAY_RST), "delay");
		rd(OFS_IRQ_MASK, 32'h0000_0000, "mask");
		rd(8'h40, 32'h0000_0000, "unmapped");
		chk("pslverr", 1, err);
		apb(1'b1, OFS_EVT_CTRL, 32'h0000_0011);
		rd(OFS_EVT_CTRL, 32'h0000_0000, "evt_ctrl");
		apb(1'b1, OFS_PULSE_PERIOD, 32'h0000_0000);
		rd(OFS_PULSE_PERIOD, 32'h0000_0001, "period_min");
		apb(1'b1, OFS_PULSE_WIDTH, 32'h0FFF_FFFF);
		rd(OFS_PULSE_WIDTH, 32'(PULSE_MAX_US), "width_max");
		apb(1'b1, OFS_STROBE_DELAY, 32'h0001_FFFF);
		rd(OFS_STROBE_DELAY, 32'h0000_FFFF, "delay_max");
	endtask
	task automatic t_manual();
		logic [7:0] cv[7] = '{8'h1A, 8'h1B, 8'h0A, 8'h0B, 8'h10, 8'h11, 8'h1D};
		logic ev[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, OFS_LINE_CTRL, 32'(cv[i]));
			repeat (3) @(posedge pclk);
			chk("line_manual", 32'(ev[i]), 32'(line));
		end
	endtask
	task automatic t_pulse();
		int wv[3] = '{0, 1, 4};
		int hv[3] = '{0, 160, 640};
		int c;
		apb(1'b1, OFS_PULSE_PERIOD, 32'h0000_0004);
		apb(1'b1, OFS_LINE_CTRL, 32'h0000_0008);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_PULSE_WIDTH, 32'(wv[i]));
			repeat (200) @(posedge pclk);
			c = 0;
			// Exactly four periods of 160 cycles, so phase does not matter
			repeat (640) begin
				@(posedge pclk);
				if (line === 1'b1) c++;
			end
			rng("pulse_high", hv[i], hv[i], c);
		end
	endtask
	task automatic t_expo();
		int c;
		apb(1'b1, OFS_LINE_CTRL, 32'h0000_0002);
		apb(1'b1, OFS_EVT_CTRL, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		frame(16'h0FA0);
		wait_sig(1, 1'b1);
		rng("win_rise", 2670, 2740, n);
		repeat (2) @(posedge pclk);
		chk("line_expo", 1, 32'(line));
		wait_sig(2, 1'b1);
		rng("evt_time", 1240, 1360, n);
		wait_sig(3, 1'b1);
		rng("irq_time", 0, 3, n);
		rd(OFS_IRQ_STATUS, 32'h0000_0001, "status");
		apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
		rd(OFS_IRQ_STATUS, 32'h0000_0000, "status_clr");
		chk("irq_clr", 0, 32'(irq));
		wait_sig(1, 1'b0);
		rng("win_fall", 2580, 2740, n);
		repeat (2) @(posedge pclk);
		chk("line_expo_end", 0, 32'(line));
		apb(1'b1, OFS_EVT_CTRL, 32'h0000_0000);
		frame(16'h00C8);
		c = 0;
		repeat (3000) begin
			@(posedge pclk);
			if (evt !== 1'b0) c++;
		end
		rng("evt_disabled", 0, 0, c);
	endtask
	task automatic t_delay();
		apb(1'b1, OFS_STROBE_DELAY, 32'h0000_0005);
		apb(1'b1, OFS_LINE_CTRL, 32'h0000_0006);
		frame(16'h0FA0);
		wait_sig(1, 1'b1);
		chk("line_pre_delay", 0, 32'(line));
		wait_sig(0, 1'b1);
		rng("strobe_lag", 160, 245, n);
		wait_sig(1, 1'b0);
		wait_sig(0, 1'b0);
	endtask
	task automatic t_readout();
		apb(1'b1, OFS_LINE_CTRL, 32'h0000_0005);
		repeat (3) @(posedge pclk);
		chk("line_ro_idle", 1, 32'(line));
		frame(16'h00C8);
		wait_sig(0, 1'b0);
		rng("ro_start", 199, 206, n);
		chk("ro_level", 1, 32'(ro));
	endtask
	task automatic t_ts();
		apb(1'b1, OFS_TS_CMD, 32'h0000_0002);
		repeat (400) @(posedge pclk);
		apb(1'b1, OFS_TS_CMD, 32'h0000_0001);
		apb(1'b0, OFS_TS_LO, 32'h0000_0000);
		rng("ts_lo", 10, 11, int'(rdat));
		rd(OFS_TS_HI, 32'h0000_0000, "ts_hi");
	endtask
	initial begin
		fail_count = 0;
		samples_checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, go} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		expo_len = 16'h0000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_manual();
		t_pulse();
		t_expo();
		t_delay();
		t_readout();
		t_ts();
		give_verdict();
	end
endmodule
`default_nettype wire
